// >>> pkg/scgo_pkg.sv
// Constants and types for the upper-opcode execute unit and its I/O bus
package scgo_pkg;
   localparam int WORD_W = 24;
   localparam int SLOT_W = 6;
   localparam int NUM_SLOTS = 4;
   localparam int NUM_IRQ = 7;
   localparam int DIV_STEPS = 25;
   localparam int PORT_W = 4;
   localparam logic [5:0] OP_DIV_STEP = 6'h16;
   localparam logic [5:0] OP_ADD = 6'h17;
   localparam logic [5:0] OP_POP_RET = 6'h18;
   localparam logic [5:0] OP_LOAD_ADDR = 6'h19;
   localparam logic [5:0] OP_DUP = 6'h1A;
   localparam logic [5:0] OP_OVER = 6'h1B;
   localparam logic [5:0] OP_PUSH_RET = 6'h1C;
   localparam logic [5:0] OP_STORE_ADDR = 6'h1D;
   localparam logic [5:0] OP_IDLE = 6'h1E;
   localparam logic [5:0] OP_DROP = 6'h1F;
   localparam logic [1:0] IO_READ_TOP = 2'h2;
   localparam logic [1:0] IO_WRITE_TOP = 2'h3;
   localparam logic [3:0] IO_IRQ_REG = 4'h0;
   localparam logic [3:0] IO_SERIAL_DATA = 4'h1;
   localparam logic [3:0] IO_CONST_ZERO = 4'h2;
   localparam logic [3:0] IO_CONST_ONE = 4'h3;
   localparam int IRQ_GLOBAL_BIT = 0;
   localparam int IRQ_ENABLE_LSB = 1;
   localparam int IRQ_STATUS_LSB = 16;
   localparam int IRQ_ANY_BIT = 23;
   localparam int IRQ_RX_LINE = 0;
   localparam int IRQ_TX_LINE = 1;
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
   localparam logic [23:0] CONST_ZERO_VALUE = 24'h000000;
   localparam logic [23:0] CONST_ONE_VALUE = 24'h000001;
   localparam logic [1:0] SLOT_FIRST = 2'h0;
   typedef enum logic [1:0] {
      SCGO_STK_NONE,
      SCGO_STK_PUSH,
      SCGO_STK_POP
   } scgo_stk_t;
endpackage : scgo_pkg

// >>> hdl/scgo_io_bus.sv
// I/O bus peripherals: interrupt enables and status, serial data, constants
`timescale 1ns/1ps
`default_nettype none
module scgo_io_bus (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [3:0] port_addr,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [23:0] wr_data,
   output logic [23:0] rd_data,
   input wire logic [6:0] irq_lines_ext,
   input wire logic rx_done,
   input wire logic tx_done,
   input wire logic [7:0] rx_char,
   output logic [7:0] tx_char,
   output logic tx_load,
   output logic [6:0] irq_lines,
   output logic [7:0] irq_enable
);
   logic [7:0] next_irq_enable;
   logic rx_flag, next_rx_flag;
   logic tx_flag, next_tx_flag;
   logic [7:0] next_tx_char;
   logic [6:0] pending;
   logic [23:0] irq_word;

   always_comb begin
      next_irq_enable = irq_enable;
      next_tx_char = tx_char;
      next_rx_flag = rx_flag;
      next_tx_flag = tx_flag;
      if (wr_stb && port_addr == scgo_pkg::IO_IRQ_REG) begin
         next_irq_enable = wr_data[7:0]; // RULE_15
      end
      if (wr_stb && port_addr == scgo_pkg::IO_SERIAL_DATA) begin
         next_tx_char = wr_data[7:0];
         next_tx_flag = 1'b0; // RULE_21
      end
      if (rd_stb && port_addr == scgo_pkg::IO_SERIAL_DATA) begin
         next_rx_flag = 1'b0; // RULE_20
      end
      // Set wins over a same-cycle clear so no event is lost
      if (rx_done) begin
         next_rx_flag = 1'b1; // RULE_20
      end
      if (tx_done) begin
         next_tx_flag = 1'b1; // RULE_21
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_enable <= scgo_pkg::IRQ_ENABLE_RESET; // RULE_18
         tx_char <= 8'h00;
         rx_flag <= 1'b0;
         tx_flag <= 1'b0;
      end else if (ce) begin
         irq_enable <= next_irq_enable;
         tx_char <= next_tx_char;
         rx_flag <= next_rx_flag;
         tx_flag <= next_tx_flag;
      end
   end

   assign tx_load = ce && wr_stb && port_addr == scgo_pkg::IO_SERIAL_DATA;
   assign irq_lines = {irq_lines_ext[6:2], tx_flag, rx_flag};
   assign pending = irq_lines & irq_enable[7:1];

   always_comb begin
      irq_word = 24'h000000; // RULE_16
      irq_word[7:0] = irq_enable; // RULE_15
      irq_word[22:16] = irq_lines; // RULE_17
      irq_word[scgo_pkg::IRQ_ANY_BIT] = |pending; // RULE_17
   end

   always_comb begin
      case (port_addr) // RULE_14
         scgo_pkg::IO_IRQ_REG: rd_data = irq_word;
         scgo_pkg::IO_SERIAL_DATA: rd_data = {16'h0000, rx_char};
         scgo_pkg::IO_CONST_ZERO: rd_data = scgo_pkg::CONST_ZERO_VALUE;
         scgo_pkg::IO_CONST_ONE: rd_data = scgo_pkg::CONST_ONE_VALUE;
         default: rd_data = 24'h000000;
      endcase
   end
endmodule : scgo_io_bus
`default_nettype wire

// >>> hdl/scgo_core.sv
// Execute unit for opcodes 16..1F and I/O bus read/write instructions
// Functional notes
// RULE_01: Divide step: conditional add, shift pair left
// RULE_02: 25 steps divide pair by negated second
// RULE_03: Opcode 17 pops second, adds, sets carry
// RULE_04: Opcode 18 return top to accumulator, push
// RULE_05: Opcode 19 address to accumulator, push
// RULE_06: Opcode 1A duplicates accumulator onto stack
// RULE_07: Opcode 1B copies second, pushes accumulator
// RULE_08: Opcode 1C pops second, accumulator to return
// RULE_09: Opcode 1D pops second, accumulator to address
// RULE_10: Opcode 1E idles, advances to next slot
// RULE_11: Opcode 1F pops second, drops accumulator
// RULE_12: Read port into accumulator, push old
// RULE_13: Write accumulator to port, pop second
// RULE_14: Port map: irq, serial, zero, one
// RULE_15: Interrupt bit0 global, bits 1-7 enables
// RULE_16: Interrupt bits 8-15 read zero
// RULE_17: Bits 16-22 line status, 23 enabled OR
// RULE_18: Reset clears all interrupt enables
// RULE_19: Block servicing until interrupt return executes
// RULE_20: Receive line set on char, cleared reading
// RULE_21: Transmit line set on done, cleared writing
// RULE_22: Divide step is opcode 16, carry kept
// RULE_23: Four slots per word, high slot first
// RULE_24: Lowest pending enabled line serviced first
`timescale 1ns/1ps
`default_nettype none
module scgo_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic word_valid,
   input wire logic [23:0] word_in,
   output logic word_req,
   input wire logic interrupt_return_op,
   input wire logic [23:0] second_in,
   input wire logic [23:0] return_top_in,
   output logic [23:0] accumulator_reg,
   output logic [23:0] address_reg,
   output logic carry,
   output scgo_pkg::scgo_stk_t data_stack_op,
   output logic [23:0] data_push_value,
   output scgo_pkg::scgo_stk_t return_stack_op,
   output logic [23:0] return_push_value,
   output logic [1:0] slot_index,
   input wire logic [6:0] irq_lines_ext,
   input wire logic rx_done,
   input wire logic tx_done,
   input wire logic [7:0] rx_char,
   output logic [7:0] tx_char,
   output logic tx_load,
   output logic irq_take,
   output logic [2:0] irq_vector
);
   logic [23:0] word_reg, next_word_reg;
   logic word_full, next_word_full;
   logic [1:0] next_slot_index;
   logic [23:0] next_accumulator, next_address;
   logic next_carry;
   logic irq_blocked, next_irq_blocked;
   logic [5:0] opcode;
   logic exec;
   logic [24:0] sum;
   logic [23:0] div_acc;
   logic [23:0] io_rd_data;
   logic io_rd, io_wr;
   logic [7:0] irq_enable;
   logic [6:0] irq_lines;
   logic [6:0] pending;
   logic any_pending;
   logic [2:0] first_line;
   logic [6:0] lower_busy;
   logic [6:0] winner;

   scgo_io_bus u_io (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .port_addr(opcode[3:0]),
      .rd_stb(io_rd),
      .wr_stb(io_wr),
      .wr_data(accumulator_reg),
      .rd_data(io_rd_data),
      .irq_lines_ext(irq_lines_ext),
      .rx_done(rx_done),
      .tx_done(tx_done),
      .rx_char(rx_char),
      .tx_char(tx_char),
      .tx_load(tx_load),
      .irq_lines(irq_lines),
      .irq_enable(irq_enable)
   );

   // Slots taken from the top of the word down
   always_comb begin
      case (slot_index) // RULE_23
         2'd0: opcode = word_reg[23:18];
         2'd1: opcode = word_reg[17:12];
         2'd2: opcode = word_reg[11:6];
         default: opcode = word_reg[5:0];
      endcase
   end

   assign exec = ce && word_full;
   assign io_rd = exec && opcode[5:4] == scgo_pkg::IO_READ_TOP;
   assign io_wr = exec && opcode[5:4] == scgo_pkg::IO_WRITE_TOP;
   assign sum = {1'b0, accumulator_reg} + {1'b0, second_in};
   // Keep the sum only if it carried
   assign div_acc = sum[24] ? sum[23:0] : accumulator_reg; // RULE_01

   // Interrupts are only taken between words, so no slot state is lost
   assign pending = irq_lines & irq_enable[7:1];
   assign any_pending = |pending;

   // A line wins only while no lower-numbered line is pending
   generate
      for (genvar g = 0; g < scgo_pkg::NUM_IRQ; g++) begin : g_prio
         if (g == 0) begin : g_head
            assign lower_busy[g] = 1'b0;
         end else begin : g_link
            assign lower_busy[g] = lower_busy[g - 1] | pending[g - 1];
         end
         assign winner[g] = pending[g] & ~lower_busy[g]; // RULE_24
      end
   endgenerate

   // Winner is one-hot, so scan order does not matter
   always_comb begin
      first_line = 3'd0;
      for (int i = 0; i < scgo_pkg::NUM_IRQ; i++) begin
         if (winner[i]) begin
            first_line = 3'(i); // RULE_24
         end
      end
   end

   assign irq_take = ce && !word_full && word_valid && !irq_blocked
      && irq_enable[scgo_pkg::IRQ_GLOBAL_BIT] && any_pending;
   assign irq_vector = first_line;
   assign word_req = !word_full;

   always_comb begin
      next_accumulator = accumulator_reg;
      next_address = address_reg;
      next_carry = carry;
      data_stack_op = scgo_pkg::SCGO_STK_NONE;
      data_push_value = accumulator_reg;
      return_stack_op = scgo_pkg::SCGO_STK_NONE;
      return_push_value = accumulator_reg;
      if (word_full) begin
         if (opcode[5]) begin
            if (opcode[4]) begin
               next_accumulator = second_in; // RULE_13
               data_stack_op = scgo_pkg::SCGO_STK_POP; // RULE_13
            end else begin
               next_accumulator = io_rd_data; // RULE_12
               data_stack_op = scgo_pkg::SCGO_STK_PUSH; // RULE_12
            end
         end else begin
            case (opcode)
               scgo_pkg::OP_DIV_STEP: begin
                  // Carry flag itself is left alone
                  {next_accumulator, next_address} =
                     {div_acc[22:0], address_reg, sum[24]}; // RULE_01 RULE_02 RULE_22
               end
               scgo_pkg::OP_ADD: begin
                  next_accumulator = sum[23:0]; // RULE_03
                  next_carry = sum[24]; // RULE_03
                  data_stack_op = scgo_pkg::SCGO_STK_POP;
               end
               scgo_pkg::OP_POP_RET: begin
                  next_accumulator = return_top_in; // RULE_04
                  return_stack_op = scgo_pkg::SCGO_STK_POP;
                  data_stack_op = scgo_pkg::SCGO_STK_PUSH; // RULE_04
               end
               scgo_pkg::OP_LOAD_ADDR: begin
                  next_accumulator = address_reg; // RULE_05
                  data_stack_op = scgo_pkg::SCGO_STK_PUSH;
               end
               scgo_pkg::OP_DUP: begin
                  data_stack_op = scgo_pkg::SCGO_STK_PUSH; // RULE_06
               end
               scgo_pkg::OP_OVER: begin
                  next_accumulator = second_in; // RULE_07
                  data_stack_op = scgo_pkg::SCGO_STK_PUSH;
               end
               scgo_pkg::OP_PUSH_RET: begin
                  next_accumulator = second_in; // RULE_08
                  data_stack_op = scgo_pkg::SCGO_STK_POP;
                  return_stack_op = scgo_pkg::SCGO_STK_PUSH; // RULE_08
               end
               scgo_pkg::OP_STORE_ADDR: begin
                  next_accumulator = second_in; // RULE_09
                  next_address = accumulator_reg; // RULE_09
                  data_stack_op = scgo_pkg::SCGO_STK_POP;
               end
               scgo_pkg::OP_DROP: begin
                  next_accumulator = second_in; // RULE_11
                  data_stack_op = scgo_pkg::SCGO_STK_POP;
               end
               default: begin
                  // Idle slot and lower opcodes: nothing here
               end
            endcase
         end
      end
      if (!ce) begin
         data_stack_op = scgo_pkg::SCGO_STK_NONE;
         return_stack_op = scgo_pkg::SCGO_STK_NONE;
      end
   end

   // Idle slot simply steps on rather than skipping to the fetch
   always_comb begin
      next_word_reg = word_reg;
      next_word_full = word_full;
      next_slot_index = slot_index;
      if (word_full) begin
         next_slot_index = slot_index + 2'd1; // RULE_10 RULE_23
         if (slot_index == 2'd3) begin
            next_word_full = 1'b0; // RULE_23
         end
      end else if (word_valid && !irq_take) begin
         next_word_reg = word_in;
         next_word_full = 1'b1;
         next_slot_index = scgo_pkg::SLOT_FIRST;
      end
   end

   // Blocking leaves the global enable alone; a take beats a return
   always_comb begin
      next_irq_blocked = irq_blocked;
      if (irq_take) begin
         next_irq_blocked = 1'b1; // RULE_19
      end else if (interrupt_return_op) begin
         next_irq_blocked = 1'b0; // RULE_19
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         word_reg <= 24'h000000;
         word_full <= 1'b0;
         slot_index <= scgo_pkg::SLOT_FIRST;
      end else if (ce) begin
         word_reg <= next_word_reg;
         word_full <= next_word_full;
         slot_index <= next_slot_index;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         accumulator_reg <= 24'h000000;
         address_reg <= 24'h000000;
         carry <= 1'b0;
      end else if (ce) begin
         accumulator_reg <= next_accumulator;
         address_reg <= next_address;
         carry <= next_carry;
      end
   end

   // A return pulse that arrives while frozen is not remembered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_blocked <= 1'b0;
      end else if (ce) begin
         irq_blocked <= next_irq_blocked;
      end
   end
endmodule : scgo_core
`default_nettype wire

// >>> sim/scgo_core_sva.sv
// Port-level checker for the execute unit
`timescale 1ns/1ps
`default_nettype none
module scgo_core_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic word_valid,
   input wire logic [23:0] word_in,
   input wire logic word_req,
   input wire logic [23:0] second_in,
   input wire logic [23:0] return_top_in,
   input wire logic [23:0] accumulator_reg,
   input wire logic [23:0] address_reg,
   input wire logic carry,
   input wire scgo_pkg::scgo_stk_t data_stack_op,
   input wire scgo_pkg::scgo_stk_t return_stack_op,
   input wire logic [23:0] return_push_value,
   input wire logic [1:0] slot_index,
   input wire logic [7:0] tx_char,
   input wire logic tx_load,
   input wire logic irq_take
);
   logic [23:0] held;
   logic [5:0] op;
   logic run;
   logic take;
   assign take = ce && word_req && word_valid && !irq_take;
   assign run = ce && !word_req;
   assign op = held[(23 - 6 * slot_index) -: 6];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) held <= 24'h000000;
      else if (take) held <= word_in;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence slots_s;
      slot_index == 2'h0 ##1 slot_index == 2'h1 ##1 slot_index == 2'h2 ##1 slot_index == 2'h3;
   endsequence
   slot_order_a: assert property (take |=> slots_s ##1 word_req)
      else $error("slot order wrong");
   div_step_a: assert property (run && op == scgo_pkg::OP_DIV_STEP |=> $stable(carry) &&
      address_reg[0] == (({1'b0, $past(accumulator_reg)} + {1'b0, $past(second_in)}) > 25'h0FFFFFF))
      else $error("divide step wrong");
   add_sum_a: assert property (run && op == scgo_pkg::OP_ADD |=>
      {carry, accumulator_reg} == {1'b0, $past(accumulator_reg)} + {1'b0, $past(second_in)})
      else $error("add wrong");
   pop_ret_a: assert property (run && op == scgo_pkg::OP_POP_RET |->
      data_stack_op == scgo_pkg::SCGO_STK_PUSH && return_stack_op == scgo_pkg::SCGO_STK_POP
      ##1 accumulator_reg == $past(return_top_in)) else $error("return pop wrong");
   load_addr_a: assert property (run && op == scgo_pkg::OP_LOAD_ADDR |=>
      accumulator_reg == $past(address_reg) && $stable(carry)) else $error("address load wrong");
   dup_keep_a: assert property (run && op == scgo_pkg::OP_DUP |->
      data_stack_op == scgo_pkg::SCGO_STK_PUSH ##1 $stable(accumulator_reg))
      else $error("dup wrong");
   push_ret_a: assert property (run && op == scgo_pkg::OP_PUSH_RET |->
      return_stack_op == scgo_pkg::SCGO_STK_PUSH && return_push_value == accumulator_reg &&
      data_stack_op == scgo_pkg::SCGO_STK_POP) else $error("return push wrong");
   store_addr_a: assert property (run && op == scgo_pkg::OP_STORE_ADDR |=>
      address_reg == $past(accumulator_reg) && accumulator_reg == $past(second_in))
      else $error("address store wrong");
   port_write_a: assert property (run && op[5:4] == 2'h3 |->
      data_stack_op == scgo_pkg::SCGO_STK_POP ##1 accumulator_reg == $past(second_in))
      else $error("port write wrong");
   tx_load_a: assert property (run && op == 6'h31 |-> tx_load ##1
      {16'h0000, tx_char} == ($past(accumulator_reg) & 24'h0000FF)) else $error("serial write wrong");
endmodule : scgo_core_sva
bind scgo_core scgo_core_sva u_sva (.clk, .rst, .ce, .word_valid, .word_in, .word_req,
   .second_in, .return_top_in, .accumulator_reg, .address_reg, .carry, .data_stack_op,
   .return_stack_op, .return_push_value, .slot_index, .tx_char, .tx_load, .irq_take);
`default_nettype wire

// >>> sim/scgo_stk_model.sv
// Data and return stack model facing the execute unit
`timescale 1ns/1ps
`default_nettype none
module scgo_stk_model (
   input wire logic clk,
   input wire scgo_pkg::scgo_stk_t dop,
   input wire logic [23:0] dval,
   input wire scgo_pkg::scgo_stk_t rop,
   input wire logic [23:0] rval,
   output logic [23:0] s_top,
   output logic [23:0] r_top
);
   logic [23:0] ds [32];
   logic [23:0] rs [32];
   logic [4:0] dp = 5'h00;
   logic [4:0] rp = 5'h00;
   // Circular storage; bench preloads it so a pop never shows stale unknowns
   assign s_top = ds[dp - 5'h01];
   assign r_top = rs[rp - 5'h01];
   task put(input logic sel, input logic [23:0] v);
      if (sel) begin
         rs[rp] = v;
         rp = rp + 5'h01;
      end else begin
         ds[dp] = v;
         dp = dp + 5'h01;
      end
   endtask : put
   always @(posedge clk) begin
      if (dop == scgo_pkg::SCGO_STK_PUSH) ds[dp] <= dval;
      if (dop != scgo_pkg::SCGO_STK_NONE) dp <= dp + ((dop == scgo_pkg::SCGO_STK_PUSH) ? 5'h01 : 5'h1F);
      if (rop == scgo_pkg::SCGO_STK_PUSH) rs[rp] <= rval;
      if (rop != scgo_pkg::SCGO_STK_NONE) rp <= rp + ((rop == scgo_pkg::SCGO_STK_PUSH) ? 5'h01 : 5'h1F);
   end
endmodule : scgo_stk_model
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the execute unit and its port peripherals
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic word_valid = 1'b0;
   logic [23:0] word_in = 24'h000000;
   logic iret = 1'b0;
   logic [6:0] lines = 7'h00;
   logic rx_done = 1'b0;
   logic tx_done = 1'b0;
   logic [7:0] rx_char = 8'h00;
   logic word_req, carry, tx_load, irq_take, mC, rxf, txf, took;
   logic [23:0] acc, adr, s_top, r_top, rpv, dpv, mT, mA, tmask;
   logic [1:0] slot;
   logic [2:0] vec, tvec;
   logic [7:0] tx_char, men, etx;
   scgo_pkg::scgo_stk_t dop, rop;
   logic [31:0] seed = 32'h00000012;
   logic [23:0] md [32];
   logic [23:0] mr [32];
   logic [4:0] mdp = 5'h00;
   logic [4:0] mrp = 5'h00;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   scgo_core u_dut (.clk(clk), .rst(rst), .ce(ce), .word_valid(word_valid), .word_in(word_in),
      .word_req(word_req), .interrupt_return_op(iret), .second_in(s_top), .return_top_in(r_top),
      .accumulator_reg(acc), .address_reg(adr), .carry(carry), .data_stack_op(dop),
      .data_push_value(dpv), .return_stack_op(rop), .return_push_value(rpv),
      .slot_index(slot), .irq_lines_ext(lines), .rx_done(rx_done), .tx_done(tx_done),
      .rx_char(rx_char), .tx_char(tx_char), .tx_load(tx_load), .irq_take(irq_take),
      .irq_vector(vec));
   scgo_stk_model u_stk (.clk(clk), .dop(dop), .dval(dpv), .rop(rop), .rval(rpv),
      .s_top(s_top), .r_top(r_top));
   initial begin
      forever #5 clk = ~clk;
   end
   function automatic logic [23:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[23:0];
   endfunction : rnd
   function automatic logic [23:0] ioval(input logic [3:0] g);
      logic [6:0] ln;
      ln = {lines[6:2], txf, rxf};
      if (g == 4'h0) return {|(ln & men[7:1]), ln, 8'h00, men};
      return (g == 4'h3) ? 24'h000001 : 24'h000000;
   endfunction : ioval
   task automatic results();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic load(input logic sel, input logic [23:0] v);
      u_stk.put(sel, v);
      if (sel) begin
         mr[mrp] = v;
         mrp++;
      end else begin
         md[mdp] = v;
         mdp++;
      end
   endtask : load
   task automatic mstep(input logic [5:0] op);
      logic [24:0] s;
      logic [23:0] s0;
      s0 = md[mdp - 5'h01];
      s = {1'b0, mT} + {1'b0, s0};
      if (op == 6'h16) begin
         {mT, mA} = {(s[24] ? s[22:0] : mT[22:0]), mA, s[24]};
      end else if (op == 6'h17) begin
         {mC, mT} = s;
         mdp--;
      end else if (op == 6'h18) begin
         md[mdp] = mT;
         mdp++;
         mrp--;
         mT = mr[mrp];
      end else if (op == 6'h19 || op == 6'h1A || op == 6'h1B || op[5:4] == 2'h2) begin
         md[mdp] = mT;
         mdp++;
         if (op == 6'h19) mT = mA;
         if (op == 6'h1B) mT = s0;
         if (op[5:4] == 2'h2) mT = ioval(op[3:0]);
         if (op == 6'h21) begin
            // Upper bits of a serial read are left unchecked
            mT = {16'h0000, rx_char};
            rxf = 1'b0;
            tmask = 24'h0000FF;
         end
      end else if (op == 6'h1C) begin
         mr[mrp] = mT;
         mrp++;
         mT = s0;
         mdp--;
      end else if (op == 6'h1D || op == 6'h1F || op[5:4] == 2'h3) begin
         if (op == 6'h1D) mA = mT;
         if (op == 6'h30) men = mT[7:0];
         if (op == 6'h31) txf = 1'b0;
         if (op == 6'h31) etx = mT[7:0];
         mT = s0;
         mdp--;
      end
   endtask : mstep
   task automatic run(input logic [23:0] w);
      @(posedge clk);
      word_in <= w;
      word_valid <= 1'b1;
      took = 1'b0;
      do begin
         @(posedge clk);
         if (irq_take === 1'b1) took = 1'b1;
         if (irq_take === 1'b1) tvec = vec;
      end while (!(word_req === 1'b1 && irq_take === 1'b0));
      word_valid <= 1'b0;
      tmask = 24'hFFFFFF;
      for (int k = 3; k >= 0; k--) begin
         @(posedge clk);
         mstep(w[6 * k +: 6]);
      end
      #1;
      chk(acc & tmask, mT & tmask);
      chk(adr, mA);
      chk({23'h000000, carry}, {23'h000000, mC});
   endtask : run
   task automatic strobe(input int k);
      @(posedge clk);
      rx_done <= (k == 0);
      tx_done <= (k == 1);
      iret <= (k == 2);
      @(posedge clk);
      rx_done <= 1'b0;
      tx_done <= 1'b0;
      iret <= 1'b0;
   endtask : strobe
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   initial begin
      logic [23:0] w, r, d, a, b;
      logic [47:0] q, m;
      {mT, mA, mC, men, rxf, txf} = 59'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      for (int i = 0; i < 32; i++) begin
         load(1'b0, rnd());
         load(1'b1, rnd());
      end
      run({6'h20, 6'h1E, 6'h1E, 6'h1E});
      run({6'h22, 6'h23, 6'h2A, 6'h32});
      $display("reset test done");
      repeat (200) begin
         w = rnd();
         for (int k = 0; k < 4; k++) begin
            if (w[6 * k +: 6] inside {6'h21, 6'h30, 6'h31}) w[6 * k +: 6] = 6'h1E;
         end
         r = rnd();
         lines <= r[6:0];
         run(w);
      end
      $display("random test done");
      d = (rnd() & 24'h3FFFFF) | 24'h000001;
      r = rnd();
      b = r % d;
      a = rnd();
      q = {b, a} / {24'h000000, d};
      m = {b, a} % {24'h000000, d};
      load(1'b0, 24'h000000 - d);
      load(1'b0, b);
      load(1'b0, a);
      run({6'h1F, 6'h1D, 6'h16, 6'h16});
      repeat (5) run({4{6'h16}});
      run({6'h16, 6'h16, 6'h16, 6'h1E});
      chk(adr, q[23:0]);
      chk(acc, {m[22:0], 1'b0});
      $display("divide test done");
      rx_char <= r[15:8];
      strobe(0);
      rxf = 1'b1;
      run({6'h20, 6'h1E, 6'h1E, 6'h1E});
      run({6'h21, 6'h1E, 6'h1E, 6'h1E});
      run({6'h1F, 6'h20, 6'h1E, 6'h1E});
      strobe(1);
      txf = 1'b1;
      run({6'h20, 6'h1E, 6'h1E, 6'h1E});
      load(1'b0, rnd() | 24'h000080);
      run({6'h1F, 6'h31, 6'h20, 6'h1E});
      chk({16'h0000, tx_char}, {16'h0000, etx});
      $display("serial test done");
      // Frozen: offered word must wait and a receive pulse is not kept
      @(posedge clk);
      ce <= 1'b0;
      word_valid <= 1'b1;
      rx_done <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({23'h000000, word_req}, 24'h000001);
      @(posedge clk);
      ce <= 1'b1;
      word_valid <= 1'b0;
      rx_done <= 1'b0;
      run({6'h20, 6'h1E, 6'h1E, 6'h1E});
      $display("freeze test done");
      lines <= 7'h0C;
      load(1'b0, 24'h000019);
      run({6'h1F, 6'h30, 6'h20, 6'h1E});
      run({6'h20, 6'h1E, 6'h1E, 6'h1E});
      chk({23'h000000, took}, 24'h000001);
      chk({21'h000000, tvec}, 24'h000002);
      run({6'h20, 6'h1E, 6'h1E, 6'h1E});
      chk({23'h000000, took}, 24'h000000);
      strobe(2);
      run({6'h20, 6'h1E, 6'h1E, 6'h1E});
      chk({23'h000000, took}, 24'h000001);
      $display("interrupt test done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      {mT, mA, mC, men, rxf, txf} = 59'h0;
      run({6'h20, 6'h1E, 6'h1E, 6'h1E});
      chk({23'h000000, took}, 24'h000000);
      $display("second reset test done");
      results();
   end
endmodule : tb
`default_nettype wire
